/* hw/dioc_pkg.sv */
// package: constants, register map and carriers of the digital i/o block
package dioc_pkg;
  // ----------------------------------------------------------------
  // line geometry
  // ----------------------------------------------------------------
  localparam int PORT_W = 16;
  localparam int LINES = 32;
  localparam int GRP_W = 8;
  localparam int NGRP = 4;
  localparam int SEL_W = 5;
  localparam int CNT_N = 3;
  localparam int CNT_W = 32;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_DIR = 8'h00;
  localparam logic [7:0] ADR_OUT = 8'h04;
  localparam logic [7:0] ADR_IN = 8'h08;
  localparam logic [7:0] ADR_MODE = 8'h0C;
  localparam logic [7:0] ADR_CFG0 = 8'h10;
  localparam logic [7:0] ADR_CNT0 = 8'h20;
  localparam logic [7:0] ADR_STEP = 8'h04;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] DIR_RST = 4'hC;
  localparam logic [31:0] OUT_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 100_000_000;
  localparam longint SINGLE_MAX_HZ = 16_000_000;
  localparam longint QUAD_MAX_HZ = 4_000_000;
  localparam int SINGLE_PER_CYC = int'(CLK_HZ / SINGLE_MAX_HZ);
  localparam int QUAD_PER_CYC = int'(CLK_HZ / QUAD_MAX_HZ);
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SEL_W-1:0] sel_r;
    logic [SEL_W-1:0] sel_b;
    logic [SEL_W-1:0] sel_a;
    logic rst_en;
    logic quad;
    logic en;
  } dioc_cfg_s;
  localparam int CFG_W = 3 * SEL_W + 3;
  typedef struct packed {
    logic a;
    logic b;
    logic r;
  } dioc_smp_s;
endpackage

/* hw/dioc_top.sv */
// digital i/o block: two 16-line ports, line counters, wishbone slave
//
// Behaviour
// - There are two ports of 16 lines each and every line may be input or output.
// - Direction is set by software per group of 8 adjacent lines.
// - After reset the first port is all inputs and the second all outputs.
// - Three independent 32-bit counters are fed from the digital lines.
// - Count, second phase and reset input of each counter select any line.
// - A line feeds a counter only once software has put it in counter mode.
// - Single-phase mode adds one per input pulse, up to 16 MHz.
// - A counter at its top value wraps to zero and carries on.
// - An assigned external reset line forces its counter to zero at any time.
// - Encoder mode counts up or down from two phases, up to 4 MHz.
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module dioc_counter
  import dioc_pkg::*;
#(
  parameter int CW = CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input dioc_cfg_s cfg,
  input dioc_smp_s cur,
  input dioc_smp_s prev,
  input wire logic ld,
  input wire logic [CW-1:0] ld_val,
  // count
  output logic [CW-1:0] cnt
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic step;
  logic up;
  logic hard;

  assign cnt = cnt_r;
  assign hard = cfg.rst_en & cur.r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    up = 1'b1;
    if (cfg.quad) begin
      // one phase moved; direction from new a against old b
      step = (cur.a ^ prev.a) ^ (cur.b ^ prev.b);
      up = cur.a ^ prev.b;
    end else begin
      step = cur.a & ~prev.a;
    end
    step = step & cfg.en;
    if (hard) begin
      cnt_nxt = '0;
    end else if (ld) begin
      cnt_nxt = ld_val;
    end else if (step && up) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (step) begin
      cnt_nxt = cnt_r - 1'b1;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_wrap;
    @(posedge clk) disable iff (rst)
    cnt_r == '1 && step && up && !hard && !ld |=> cnt_r == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_ext_rst;
    @(posedge clk) disable iff (rst)
    cfg.rst_en && cur.r |=> cnt_r == '0;
  endproperty
  a_ext_rst: assert property (p_ext_rst) else $error("external reset ignored");

  property p_single;
    @(posedge clk) disable iff (rst)
    !cfg.quad && cfg.en && cur.a && !prev.a && !hard && !ld
      |=> cnt_r == CW'($past(cnt_r) + 1'b1);
  endproperty
  a_single: assert property (p_single) else $error("pulse not counted");

  property p_quad_up;
    @(posedge clk) disable iff (rst)
    cfg.quad && cfg.en && !prev.a && !prev.b && cur.a && !cur.b && !hard && !ld
      |=> cnt_r == CW'($past(cnt_r) + 1'b1);
  endproperty
  a_quad_up: assert property (p_quad_up) else $error("leading a not up");

  property p_quad_dn;
    @(posedge clk) disable iff (rst)
    cfg.quad && cfg.en && !prev.a && !prev.b && !cur.a && cur.b && !hard && !ld
      |=> cnt_r == CW'($past(cnt_r) - 1'b1);
  endproperty
  a_quad_dn: assert property (p_quad_dn) else $error("lagging a not down");
endmodule

module dioc_top
  import dioc_pkg::*;
#(
  parameter int NCNT = CNT_N,
  parameter int CW = CNT_W
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // wishbone slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_W,
  output logic [31:0] WB_DAT_R,
  output logic WB_ACK,
  // port a pins
  input wire logic [PORT_W-1:0] PA_LVL,
  output logic [PORT_W-1:0] PA_DRV,
  output logic [PORT_W-1:0] PA_OE_N,
  // port b pins
  input wire logic [PORT_W-1:0] PB_LVL,
  output logic [PORT_W-1:0] PB_DRV,
  output logic [PORT_W-1:0] PB_OE_N
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NCNT < 1 || NCNT > 4 || CW < 2 || CW > 32 || SINGLE_PER_CYC < 2) begin : g_bad
    $error("dioc_top: unsupported parameters");
  end

  function automatic logic [31:0] dioc_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] m;
    m = old_v;
    for (int k = 0; k < 4; k++) begin
      if (sel[k]) begin
        m[k*8+:8] = new_v[k*8+:8];
      end
    end
    return m;
  endfunction

  function automatic logic [LINES-1:0] dioc_grp_oe(input logic [NGRP-1:0] d);
    logic [LINES-1:0] o;
    o = '0;
    for (int g = 0; g < NGRP; g++) begin
      o[g*GRP_W+:GRP_W] = {GRP_W{~d[g]}};
    end
    return o;
  endfunction

  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd;
  logic req;
  logic wr_hit;
  logic [7:0] adr_w;
  logic [LINES-1:0] oe_n_r;
  logic [LINES-1:0] out_r;
  logic [LINES-1:0] mode_r;
  logic [LINES-1:0] sync1_r;
  logic [LINES-1:0] sync2_r;
  logic [LINES-1:0] prev_r;
  logic [LINES-1:0] g_cur;
  logic [LINES-1:0] g_prev;
  logic [NGRP-1:0] dir_w;
  dioc_cfg_s cfg_r [NCNT];
  logic [CW-1:0] cnt_w [NCNT];

  assign WB_ACK = ack_r;
  assign WB_DAT_R = dat_r;
  assign PA_DRV = out_r[PORT_W-1:0];
  assign PB_DRV = out_r[LINES-1:PORT_W];
  assign PA_OE_N = oe_n_r[PORT_W-1:0];
  assign PB_OE_N = oe_n_r[LINES-1:PORT_W];
  assign adr_w = {WB_ADR[7:2], 2'b00};
  assign req = WB_CYC & WB_STB;
  assign wr_hit = req & WB_WE & ack_r;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_comb begin
    rd = 32'h0000_0000;
    for (int g = 0; g < NGRP; g++) begin
      dir_w[g] = ~oe_n_r[g*GRP_W];
    end
    case (adr_w)
      ADR_DIR: rd = {28'h000_0000, dir_w};
      ADR_OUT: rd = out_r;
      ADR_IN: rd = sync2_r;
      ADR_MODE: rd = mode_r;
      default: rd = 32'h0000_0000;
    endcase
    for (int i = 0; i < NCNT; i++) begin
      if (adr_w == ADR_CFG0 + 8'(i * ADR_STEP)) begin
        rd = {{(32 - CFG_W){1'b0}}, cfg_r[i]};
      end
      if (adr_w == ADR_CNT0 + 8'(i * ADR_STEP)) begin
        rd = 32'(cnt_w[i]);
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      dat_r <= 32'h0000_0000;
    end else if (req && !ack_r) begin
      dat_r <= rd;
    end
  end

  // ----------------------------------------------------------------
  // direction, output data and line mode
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      oe_n_r <= dioc_grp_oe(DIR_RST);
    end else if (wr_hit && adr_w == ADR_DIR && WB_SEL[0]) begin
      oe_n_r <= dioc_grp_oe(WB_DAT_W[NGRP-1:0]);
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      out_r <= OUT_RST;
    end else if (wr_hit && adr_w == ADR_OUT) begin
      out_r <= dioc_merge(out_r, WB_DAT_W, WB_SEL);
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      mode_r <= MODE_RST;
    end else if (wr_hit && adr_w == ADR_MODE) begin
      mode_r <= dioc_merge(mode_r, WB_DAT_W, WB_SEL);
    end
  end

  // ----------------------------------------------------------------
  // input sampling
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= {PB_LVL, PA_LVL};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // only lines in counter mode reach the counters
  assign g_cur = sync2_r & mode_r;
  assign g_prev = prev_r & mode_r;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NCNT; i++) begin : g_cnt
    localparam logic [7:0] A_CFG = ADR_CFG0 + 8'(i * ADR_STEP);
    localparam logic [7:0] A_CNT = ADR_CNT0 + 8'(i * ADR_STEP);
    logic [31:0] cfg_m;
    logic [31:0] ld_m;
    dioc_smp_s cur;
    dioc_smp_s prv;

    assign cfg_m = dioc_merge({{(32 - CFG_W){1'b0}}, cfg_r[i]}, WB_DAT_W, WB_SEL);
    assign ld_m = dioc_merge(32'(cnt_w[i]), WB_DAT_W, WB_SEL);
    assign cur = '{a: g_cur[cfg_r[i].sel_a], b: g_cur[cfg_r[i].sel_b],
                   r: g_cur[cfg_r[i].sel_r]};
    assign prv = '{a: g_prev[cfg_r[i].sel_a], b: g_prev[cfg_r[i].sel_b],
                   r: g_prev[cfg_r[i].sel_r]};

    always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
        cfg_r[i] <= '0;
      end else if (wr_hit && adr_w == A_CFG) begin
        cfg_r[i] <= dioc_cfg_s'(cfg_m[CFG_W-1:0]);
      end
    end

    dioc_counter #(.CW(CW)) u_cnt (
      .clk(MCLK),
      .rst(SYS_RST),
      .cfg(cfg_r[i]),
      .cur(cur),
      .prev(prv),
      .ld(wr_hit && adr_w == A_CNT),
      .ld_val(ld_m[CW-1:0]),
      .cnt(cnt_w[i])
    );
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_dir_reset;
    @(posedge MCLK) disable iff (SYS_RST)
    $fell(SYS_RST) |-> PA_OE_N == '1 && PB_OE_N == '0;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("bad reset direction");

  property p_groups;
    @(posedge MCLK) disable iff (SYS_RST)
    (PA_OE_N[7:0] == 8'h00 || PA_OE_N[7:0] == 8'hFF) &&
    (PA_OE_N[15:8] == 8'h00 || PA_OE_N[15:8] == 8'hFF) &&
    (PB_OE_N[7:0] == 8'h00 || PB_OE_N[7:0] == 8'hFF) &&
    (PB_OE_N[15:8] == 8'h00 || PB_OE_N[15:8] == 8'hFF);
  endproperty
  a_groups: assert property (p_groups) else $error("direction split in group");

  property p_dir_write;
    @(posedge MCLK) disable iff (SYS_RST)
    wr_hit && adr_w == ADR_DIR && WB_SEL[0] && WB_DAT_W[0]
      |=> PA_OE_N[7:0] == 8'h00;
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("group not driven");

  property p_sync;
    @(posedge MCLK) disable iff (SYS_RST)
    !$past(SYS_RST) && !$past(SYS_RST, 2) |-> sync2_r == $past({PB_LVL, PA_LVL}, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("input sync delay wrong");

  property p_gate;
    @(posedge MCLK) disable iff (SYS_RST)
    mode_r == '0 && !wr_hit |=> cnt_w[0] == $past(cnt_w[0]);
  endproperty
  a_gate: assert property (p_gate) else $error("plain line moved counter");

  property p_ack;
    @(posedge MCLK) disable iff (SYS_RST)
    req && !WB_ACK |=> WB_ACK ##1 !WB_ACK;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
endmodule

/* bench/dioc_field.sv */
// field side of one port: sources on input lines, pull-down elsewhere
`timescale 1ns/1ps

module dioc_field
  import dioc_pkg::*;
(
  // device side
  input wire logic [PORT_W-1:0] drv,
  input wire logic [PORT_W-1:0] oe_n,
  // field side
  input wire logic [PORT_W-1:0] ext,
  input wire logic [PORT_W-1:0] ext_en,
  output logic [PORT_W-1:0] lvl
);
  // sources only drive lines the device leaves as inputs; undriven lines pull low
  assign lvl = (~oe_n & drv) | (oe_n & ext_en & ext);
endmodule

/* bench/tb.sv */
// self-checking bench of the digital i/o block
`timescale 1ns/1ps

module tb
  import dioc_pkg::*;
;
  logic mclk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0, wsel = 4'hF;
  logic [31:0] dw = 0, dr, ext = 0, q, mdl_out, v, m;
  logic ack;
  logic [15:0] pa_lvl, pa_drv, pa_oe_n, pb_lvl, pb_drv, pb_oe_n;
  logic [31:0] mdl_cnt [3];
  logic [3:0] d;
  int error_cnt = 0, num_checks = 0, ln, qs = 0;

  initial forever #5 mclk = ~mclk;

  dioc_top dioc_top_inst (.MCLK(mclk), .SYS_RST(rst), .WB_CYC(cyc), .WB_STB(stb),
    .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_W(dw), .WB_DAT_R(dr), .WB_ACK(ack),
    .PA_LVL(pa_lvl), .PA_DRV(pa_drv), .PA_OE_N(pa_oe_n),
    .PB_LVL(pb_lvl), .PB_DRV(pb_drv), .PB_OE_N(pb_oe_n));
  dioc_field dioc_field_a_inst (.drv(pa_drv), .oe_n(pa_oe_n), .ext(ext[15:0]),
    .ext_en(16'hFFFF), .lvl(pa_lvl));
  dioc_field dioc_field_b_inst (.drv(pb_drv), .oe_n(pb_oe_n), .ext(ext[31:16]),
    .ext_en(16'hFFFF), .lvl(pb_lvl));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dw <= v;
    sel <= wsel;
    do @(posedge mclk); while (ack !== 1'b1);
    q = dr;
    cyc <= 0;
    stb <= 0;
  endtask

  function automatic logic [31:0] cfg(int a, int b, int r, bit rs, bit qd);
    return {14'h0, 5'(r), 5'(b), 5'(a), rs, qd, 1'b1};
  endfunction

  task automatic pulse(int line, int n);
    repeat (n) begin
      @(posedge mclk) ext[line] <= 1;
      repeat (3) @(posedge mclk);
      ext[line] <= 0;
      repeat (3) @(posedge mclk);
    end
  endtask

  task automatic qstep(bit up);
    logic [1:0] ab [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    qs = up ? (qs + 1) % 4 : (qs + 3) % 4;
    @(posedge mclk);
    ext[ln+12] <= ab[qs][1];
    ext[ln+16] <= ab[qs][0];
    mdl_cnt[2] = up ? mdl_cnt[2] + 1 : mdl_cnt[2] - 1;
    repeat (7) @(posedge mclk);
  endtask

  task automatic cnt_chk(int i);
    repeat (4) @(posedge mclk);
    wb(0, ADR_CNT0 + 8'(4 * i), 0);
    chk("count", q, mdl_cnt[i]);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(6));
    mdl_cnt = '{0, 0, 0};
    mdl_out = 32'h0000_0000;
    repeat (3) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    chk("pa_oe_n", pa_oe_n, 16'hFFFF);
    chk("pb_oe_n", pb_oe_n, 16'h0000);
    chk("drv", {pb_drv, pa_drv}, 32'h0000_0000);
    wb(0, ADR_DIR, 0);
    chk("dir", q, 32'h0000_000C);
    wb(0, 8'hFC, 0);
    chk("unmapped", q, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      // first pass drives every group, later passes merge random byte lanes
      d = (k == 0) ? 4'hF : 4'($urandom);
      v = $urandom;
      ext <= $urandom;
      wb(1, ADR_DIR, {28'h000_0000, d});
      wsel = (k == 0) ? 4'hF : 4'($urandom);
      for (int b = 0; b < 4; b++) begin
        if (wsel[b]) begin
          mdl_out[b*8+:8] = v[b*8+:8];
        end
      end
      wb(1, ADR_OUT, v);
      wsel = 4'hF;
      @(posedge mclk);
      chk("pa_oe_n", pa_oe_n, {{8{~d[1]}}, {8{~d[0]}}});
      chk("pb_oe_n", pb_oe_n, {{8{~d[3]}}, {8{~d[2]}}});
      chk("drv", {pb_drv, pa_drv}, mdl_out);
      m = {{8{d[3]}}, {8{d[2]}}, {8{d[1]}}, {8{d[0]}}};
      repeat (3) @(posedge mclk);
      wb(0, ADR_IN, 0);
      chk("in", q, (mdl_out & m) | (ext & ~m));
    end
    ext <= 0;
    wb(1, ADR_DIR, 0);
    ln = $urandom % 4;
    wb(1, ADR_CFG0, cfg(ln, 0, ln + 4, 1, 0));
    wb(0, ADR_CFG0, 0);
    chk("cfg", q, cfg(ln, 0, ln + 4, 1, 0));
    pulse(ln, 3);
    cnt_chk(0);
    wb(1, ADR_MODE, (32'h1_1111 << ln));
    pulse(ln, 5);
    mdl_cnt[0] = 5;
    cnt_chk(0);
    pulse(ln + 4, 1);
    mdl_cnt[0] = 0;
    cnt_chk(0);
    wb(1, ADR_CFG0 + 8'h04, cfg(ln + 8, 0, 0, 0, 0));
    wb(1, ADR_CNT0 + 8'h04, 32'hFFFF_FFFE);
    mdl_cnt[1] = 32'hFFFF_FFFE;
    pulse(ln + 8, 2);
    mdl_cnt[1] = mdl_cnt[1] + 2;
    cnt_chk(1);
    wb(1, ADR_CFG0 + 8'h08, cfg(ln + 12, ln + 16, 0, 0, 1));
    repeat (6) qstep(1);
    cnt_chk(2);
    repeat (9) qstep(0);
    cnt_chk(2);
    cnt_chk(0);
    cnt_chk(1);
    // reset in mid-run brings back the power-up directions and clears counts
    rst <= 1;
    repeat (3) @(posedge mclk);
    rst <= 0;
    mdl_cnt = '{0, 0, 0};
    @(posedge mclk);
    chk("pa_oe_n", pa_oe_n, 16'hFFFF);
    chk("pb_oe_n", pb_oe_n, 16'h0000);
    cnt_chk(2);
    report_and_stop;
  end
endmodule
